/* File: rtl/scpw_top.sv */
// single channel pwm generator with two special function registers
//
// Function
// - control bits 7-6 at 00 hold pwm off, output low.
// - codes 01, 10, 11 select 6, 7, 8 bit period.
// - period is 63, 127 or 255 clocks times prescale plus one.
// - low six control bits divide clock by value plus one for tick.
// - duty is duty register over full scale, masked to resolution.
// - new duty value applies immediately, not at period boundary.
// - control at 0xA9, duty at 0xAA, both 8-bit rw, reset zero.
`timescale 1ns/1ps
`default_nettype none
module scpw_top
    import scpw_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    output logic            PWM_OUT
);
    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [7:0] duty;
        logic [7:0] cnt;
        logic [7:0] rdata;
        logic       out;
    } scpw_s;

    scpw_s      st;
    scpw_s      next_st;
    logic       tick;
    logic [1:0] mode;
    logic [7:0] full;
    logic [7:0] mask;
    logic [7:0] duty_eff;

    assign mode = st.ctrl[MODE_HI:MODE_LO];

    // resolution decode
    always_comb
    begin
        unique case (mode)
            MODE_6BIT:
            begin
                full = FULL_6BIT;
                mask = MASK_6BIT;
            end
            MODE_7BIT:
            begin
                full = FULL_7BIT;
                mask = MASK_7BIT;
            end
            MODE_8BIT:
            begin
                full = FULL_8BIT;
                mask = MASK_8BIT;
            end
            MODE_OFF:
            begin
                full = FULL_8BIT;
                mask = 8'h00;
            end
        endcase
    end

    assign duty_eff = st.duty & mask;

    // prescale tick generator
    scpw_prescaler #(
        .W    (PRESCALE_HI - PRESCALE_LO + 1)
    ) u_pre (
        .CLK  (CLK),
        .NRST (NRST),
        .run  (mode != MODE_OFF),
        .div  (st.ctrl[PRESCALE_HI:PRESCALE_LO]),
        .tick (tick)
    );

    // register access, period counter and output compare
    always_comb
    begin
        next_st = st;
        if (SFR_WR && SFR_ADDR == ADDR_PERIOD_CONTROL)
            next_st.ctrl = SFR_WDATA;
        if (SFR_WR && SFR_ADDR == ADDR_DUTY_SETTING)
            next_st.duty = SFR_WDATA;
        if (SFR_RD)
        begin
            if (SFR_ADDR == ADDR_PERIOD_CONTROL)
                next_st.rdata = st.ctrl;
            else if (SFR_ADDR == ADDR_DUTY_SETTING)
                next_st.rdata = st.duty;
            else
                next_st.rdata = 8'h00;
        end
        if (mode == MODE_OFF)
        begin
            next_st.cnt = 8'h00;
            next_st.out = 1'b0;
        end
        else
        begin
            if (tick)
                next_st.cnt = (st.cnt >= full - 8'h01) ? 8'h00 : st.cnt + 8'h01;
            // compare against live duty so writes take effect at once
            next_st.out = (st.cnt < duty_eff);
        end
    end

    // state register
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            st       <= '0;
            st.ctrl  <= RST_PERIOD_CONTROL;
            st.duty  <= RST_DUTY_SETTING;
        end
        else
            st <= next_st;
    end

    assign SFR_RDATA = st.rdata;
    assign PWM_OUT   = st.out;

    // off mode keeps output low
    pwm_off_low_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode == MODE_OFF) |=> !PWM_OUT)
        else $error("pwm active while off");

    // off mode parks the period counter at zero
    off_cnt_zero_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode == MODE_OFF) |=> st.cnt == 8'h00)
        else $error("counter runs while off");

    // off mode keeps the prescaler quiet
    tick_off_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode == MODE_OFF) |=> !tick)
        else $error("tick while off");

    // counter stays below full scale once inside it; a mode drop may leave it above
    cnt_range_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode != MODE_OFF) && $stable(mode) && $past(st.cnt) < full |-> st.cnt < full)
        else $error("counter over range");

    // counter moves only on tick
    cnt_tick_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode != MODE_OFF) && !tick && $stable(st.ctrl) |=> $stable(st.cnt))
        else $error("count w/o tick");

    // counter steps by one on tick below the wrap point
    count_step_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode != MODE_OFF) && tick && st.cnt < full - 8'h01 |=>
            st.cnt == $past(st.cnt) + 8'h01)
        else $error("counter step wrong");

    // counter wraps at full minus one
    cnt_wrap_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode != MODE_OFF) && tick && st.cnt == full - 8'h01 && !SFR_WR |=> st.cnt == 8'h00)
        else $error("counter wrap wrong");

    // output follows compare one cycle later
    out_cmp_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode != MODE_OFF) |=> PWM_OUT == ($past(st.cnt) < $past(duty_eff)))
        else $error("bad compare");

    // duty bits above 6-bit resolution are ignored
    mask_six_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode == MODE_6BIT) |-> (duty_eff & ~MASK_6BIT) == 8'h00)
        else $error("duty mask 6 bit");

    // duty bit 7 is ignored at 7-bit resolution
    mask_seven_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode == MODE_7BIT) |-> (duty_eff & ~MASK_7BIT) == 8'h00)
        else $error("duty mask 7 bit");

    // duty write visible next cycle
    duty_write_a : assert property (@(posedge CLK) disable iff (!NRST)
        SFR_WR && SFR_ADDR == ADDR_DUTY_SETTING |=> st.duty == $past(SFR_WDATA))
        else $error("duty lost");

    // zero duty written mid-period drives output low at once
    duty_zero_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode != MODE_OFF) && SFR_WR && SFR_ADDR == ADDR_DUTY_SETTING && SFR_WDATA == 8'h00
            |=> ##1 !PWM_OUT)
        else $error("zero duty not low");

    // full duty written mid-period drives output high at once
    duty_full_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode == MODE_8BIT) && SFR_WR && SFR_ADDR == ADDR_DUTY_SETTING
            && SFR_WDATA == FULL_8BIT |=> ##1 PWM_OUT)
        else $error("full duty not high");

    // control write lands next cycle
    ctrl_write_a : assert property (@(posedge CLK) disable iff (!NRST)
        SFR_WR && SFR_ADDR == ADDR_PERIOD_CONTROL |=> st.ctrl == $past(SFR_WDATA))
        else $error("ctrl lost");

    // writes to other addresses leave both registers alone
    stray_write_a : assert property (@(posedge CLK) disable iff (!NRST)
        SFR_WR && SFR_ADDR != ADDR_PERIOD_CONTROL && SFR_ADDR != ADDR_DUTY_SETTING |=>
            $stable(st.ctrl) && $stable(st.duty))
        else $error("stray write landed");

    // control readback
    ctrl_read_a : assert property (@(posedge CLK) disable iff (!NRST)
        SFR_RD && SFR_ADDR == ADDR_PERIOD_CONTROL |=> SFR_RDATA == $past(st.ctrl))
        else $error("ctrl read");

    // duty readback
    duty_read_a : assert property (@(posedge CLK) disable iff (!NRST)
        SFR_RD && SFR_ADDR == ADDR_DUTY_SETTING |=> SFR_RDATA == $past(st.duty))
        else $error("duty read");

    // unmapped read returns zero
    unmapped_read_a : assert property (@(posedge CLK) disable iff (!NRST)
        SFR_RD && SFR_ADDR != ADDR_PERIOD_CONTROL && SFR_ADDR != ADDR_DUTY_SETTING |=>
            SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");

    // read data holds between reads
    rdata_hold_a : assert property (@(posedge CLK) disable iff (!NRST)
        !SFR_RD |=> $stable(SFR_RDATA))
        else $error("read data moved");

    // reset clears both registers, read data and output
    reset_clear_a : assert property (@(posedge CLK)
        !NRST |=> st.ctrl == RST_PERIOD_CONTROL && st.duty == RST_DUTY_SETTING
            && !PWM_OUT && SFR_RDATA == 8'h00)
        else $error("reset values wrong");

    // prescale zero ticks on every clock
    div_zero_a : assert property (@(posedge CLK) disable iff (!NRST)
        (mode != MODE_OFF) && st.ctrl[PRESCALE_HI:PRESCALE_LO] == 6'h00 |=> tick)
        else $error("tick missing at divide one");

    // no tick while prescaler count short of divisor
    tick_gap_a : assert property (@(posedge CLK) disable iff (!NRST)
        tick && st.ctrl[PRESCALE_HI:PRESCALE_LO] == 6'h01 && $stable(st.ctrl) |=> !tick)
        else $error("tick too soon");
endmodule // scpw_top
`default_nettype wire

/* File: rtl/scpw_pkg.sv */
// package: register map, field layout and constants of the pwm block
package scpw_pkg;
    // special function register addresses
    localparam logic [7:0] ADDR_PERIOD_CONTROL = 8'ha9;
    localparam logic [7:0] ADDR_DUTY_SETTING   = 8'haa;
    // reset values
    localparam logic [7:0] RST_PERIOD_CONTROL  = 8'h00;
    localparam logic [7:0] RST_DUTY_SETTING    = 8'h00;
    // control field layout
    localparam int         MODE_HI             = 7;
    localparam int         MODE_LO             = 6;
    localparam int         PRESCALE_HI         = 5;
    localparam int         PRESCALE_LO         = 0;
    // resolution select codes
    localparam logic [1:0] MODE_OFF            = 2'h0;
    localparam logic [1:0] MODE_6BIT           = 2'h1;
    localparam logic [1:0] MODE_7BIT           = 2'h2;
    localparam logic [1:0] MODE_8BIT           = 2'h3;
    // full-scale counts per resolution
    localparam logic [7:0] FULL_6BIT           = 8'h3f;
    localparam logic [7:0] FULL_7BIT           = 8'h7f;
    localparam logic [7:0] FULL_8BIT           = 8'hff;
    // duty masks per resolution
    localparam logic [7:0] MASK_6BIT           = 8'h3f;
    localparam logic [7:0] MASK_7BIT           = 8'h7f;
    localparam logic [7:0] MASK_8BIT           = 8'hff;
endpackage : scpw_pkg

/* File: rtl/scpw_prescaler.sv */
// prescaler: one-cycle tick every (div+1) clocks
`timescale 1ns/1ps
`default_nettype none
module scpw_prescaler
    import scpw_pkg::*;
#(
    parameter int W = 6
)(
    input  wire logic         CLK,
    input  wire logic         NRST,
    input  wire logic         run,
    input  wire logic [W-1:0] div,
    output logic              tick
);
    typedef struct packed
    {
        logic [W-1:0] cnt;
        logic         tick;
    } scpw_pre_s;

    scpw_pre_s st;
    scpw_pre_s next_st;

    // count up to div, then wrap and pulse
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run)
            next_st.cnt = '0;
        else if (st.cnt >= div)
        begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
        end
        else
            next_st.cnt = st.cnt + 1'b1;
    end

    // state register
    always_ff @(posedge CLK)
    begin
        if (!NRST)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;
endmodule // scpw_prescaler
`default_nettype wire

/* File: bench/tb_single_channel_pwm_output.sv */
// self-checking testbench for the pwm block
`timescale 1ns/1ps
`default_nettype none
module tb_single_channel_pwm_output
    import scpw_pkg::*;
;
    logic       CLK;
    logic       NRST;
    logic [7:0] SFR_ADDR;
    logic [7:0] SFR_WDATA;
    logic       SFR_WR;
    logic       SFR_RD;
    logic [7:0] SFR_RDATA;
    logic       PWM_OUT;
    logic [7:0] d;
    int         bad_count;
    int         num_checks;

    scpw_top dut (.CLK(CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
        .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .PWM_OUT(PWM_OUT));

    // 100 mhz clock
    always #5 CLK = ~CLK;

    // compare and count
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one register write, strobe held for one edge
    task wr(input logic [7:0] a, input logic [7:0] v);
        SFR_ADDR = a;
        SFR_WDATA = v;
        SFR_WR = 1'b1;
        @(posedge CLK);
        #1;
        SFR_WR = 1'b0;
        @(posedge CLK);
        #1;
    endtask

    // one register read, data taken a cycle later
    task rd(input logic [7:0] a, output logic [7:0] v);
        SFR_ADDR = a;
        SFR_RD = 1'b1;
        @(posedge CLK);
        #1;
        SFR_RD = 1'b0;
        @(posedge CLK);
        #1;
        v = SFR_RDATA;
    endtask

    // reset values, read back, unmapped read, off mode stays low
    task t_regs();
        int hi;
        hi = 0;
        rd(ADDR_PERIOD_CONTROL, d);
        chk(d, RST_PERIOD_CONTROL);
        rd(ADDR_DUTY_SETTING, d);
        chk(d, RST_DUTY_SETTING);
        wr(ADDR_PERIOD_CONTROL, 8'h2a);
        wr(ADDR_DUTY_SETTING, 8'h5c);
        wr(8'h55, 8'h77);
        rd(ADDR_PERIOD_CONTROL, d);
        chk(d, 8'h2a);
        rd(ADDR_DUTY_SETTING, d);
        chk(d, 8'h5c);
        rd(8'h55, d);
        chk(d, 8'h00);
        repeat (200)
        begin
            hi += (PWM_OUT !== 1'b0);
            @(posedge CLK);
            #1;
        end
        chk(hi[15:0], 16'h0000);
        $display("test regs done");
    endtask

    // one period measured from rise to rise, high time counted
    task t_meas(input logic [1:0] m, input logic [5:0] p, input logic [7:0] f, input logic [7:0] k);
        int  n, hi, ep, eh;
        logic prv;
        wr(ADDR_PERIOD_CONTROL, {m, p});
        wr(ADDR_DUTY_SETTING, 8'hc5);
        prv = 1'b1;
        n = 0;
        hi = 0;
        while (!(prv === 1'b0 && PWM_OUT === 1'b1) && n < 2000)
        begin
            prv = PWM_OUT;
            @(posedge CLK);
            #1;
            n++;
        end
        if (n >= 2000)
        begin
            bad_count++;
            summarize();
        end
        n = 0;
        do
        begin
            prv = PWM_OUT;
            @(posedge CLK);
            #1;
            n++;
            hi += (prv === 1'b1);
        end while (!(prv === 1'b0 && PWM_OUT === 1'b1) && n < 2000);
        ep = f * (p + 1);
        eh = (8'hc5 & k) * (p + 1);
        chk(n[15:0], ep[15:0]);
        chk(hi[15:0], eh[15:0]);
        $display("test period mode %0d done", m);
    endtask

    // duty change lands mid-period one cycle after the write edge
    task t_now();
        wr(ADDR_PERIOD_CONTROL, {MODE_8BIT, 6'h03});
        wr(ADDR_DUTY_SETTING, 8'h00);
        repeat (10) @(posedge CLK);
        #1;
        chk(PWM_OUT, 1'b0);
        // open-coded write so the output is seen just after the write edge
        SFR_ADDR = ADDR_DUTY_SETTING;
        SFR_WDATA = 8'hff;
        SFR_WR = 1'b1;
        @(posedge CLK);
        #1;
        SFR_WR = 1'b0;
        chk(PWM_OUT, 1'b0);
        @(posedge CLK);
        #1;
        chk(PWM_OUT, 1'b1);
        wr(ADDR_DUTY_SETTING, 8'h00);
        chk(PWM_OUT, 1'b0);
        @(posedge CLK);
        #1;
        chk(PWM_OUT, 1'b0);
        $display("test immediate duty done");
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        CLK = 1'b0;
        NRST = 1'b0;
        SFR_ADDR = 8'h00;
        SFR_WDATA = 8'h00;
        SFR_WR = 1'b0;
        SFR_RD = 1'b0;
        bad_count = 0;
        num_checks = 0;
        repeat (3) @(posedge CLK);
        #1;
        chk(PWM_OUT, 1'b0);
        NRST = 1'b1;
        t_regs();
        t_meas(MODE_6BIT, 6'h01, FULL_6BIT, MASK_6BIT);
        t_meas(MODE_7BIT, 6'h00, FULL_7BIT, MASK_7BIT);
        t_meas(MODE_8BIT, 6'h02, FULL_8BIT, MASK_8BIT);
        t_now();
        summarize();
    end
endmodule // tb_single_channel_pwm_output
`default_nettype wire
